/* File: src/bopx_exec.sv */
// Execution unit for shift/rotate, bit, status-flag and processor-control instructions.
// Assumes the decoder presents one request per cycle and that I/O read data is valid combinationally.
`timescale 1ns/10ps

module bopx_exec (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic req_valid,
    input wire bopx_pkg::bopx_req_t req,
    output logic req_ready,
    input wire logic [bopx_pkg::DATA_W-1:0] io_rdata,
    input wire logic nvm_ready,
    input wire logic [bopx_pkg::SLEEP_MODE_W-1:0] sleep_mode,
    output bopx_pkg::bopx_reg_wr_t reg_wr,
    output bopx_pkg::bopx_io_wr_t io_wr,
    output logic [bopx_pkg::DATA_W-1:0] status_flags_register,
    output logic debug_break,
    output logic sleep_req,
    output logic [bopx_pkg::SLEEP_MODE_W-1:0] sleep_mode_req,
    output logic watchdog_restart,
    output logic data_access_done,
    output logic stall
);

    // One-hot mask for a bit position
    function automatic logic [7:0] bit_mask(input logic [2:0] idx);
        logic [7:0] m;
        m = 8'h01;
        bit_mask = m << idx;
    endfunction

    // Decode of one opcode being taken this cycle
    function automatic logic op_taken(
        input logic tk,
        input bopx_pkg::bopx_op_t op,
        input bopx_pkg::bopx_op_t code
    );
        op_taken = tk && (op == code);
    endfunction

    // Flags after a shift or rotate: N, V, S and Z follow from result and carry out
    function automatic logic [7:0] shift_flags(
        input logic [7:0] old,
        input logic [7:0] res,
        input logic cout,
        input logic upd_h,
        input logic hval
    );
        logic [7:0] f;
        logic n;
        logic v;
        f = old;
        n = res[7];
        v = n ^ cout;
        f[bopx_pkg::FLAG_C] = cout;
        f[bopx_pkg::FLAG_Z] = (res == bopx_pkg::BYTE_ZERO);
        f[bopx_pkg::FLAG_N] = n;
        f[bopx_pkg::FLAG_V] = v;
        f[bopx_pkg::FLAG_S] = n ^ v;
        if (upd_h) begin
            f[bopx_pkg::FLAG_H] = hval;
        end
        shift_flags = f;
    endfunction

    bopx_pkg::bopx_state_t state;
    bopx_pkg::bopx_state_t next_state;

    logic take;
    logic [7:0] rv;
    logic [7:0] status_flags_register_cur;
    logic [7:0] next_status_flags_register;
    logic next_reg_en;
    logic [7:0] next_reg_data;
    logic next_io_en;
    logic [7:0] next_io_data;
    logic [7:0] sel_mask;
    logic ram_access;
    logic nvm_access;
    logic sleep_taken;

    assign rv = req.reg_value;
    assign status_flags_register_cur = status_flags_register;
    assign sel_mask = bit_mask(req.bit_sel);

    // The block holds off the decoder while a nonvolatile access is waiting
    assign stall = (state == bopx_pkg::ST_NVM_WAIT);
    assign req_ready = !stall;
    assign take = req_valid && req_ready;

    // Data access split by route, and the sleep decode shared by two outputs
    assign ram_access = op_taken(take, req.op, bopx_pkg::OP_DATA_ACCESS) && !req.via_nvm;
    assign nvm_access = op_taken(take, req.op, bopx_pkg::OP_DATA_ACCESS) && req.via_nvm;
    assign sleep_taken = op_taken(take, req.op, bopx_pkg::OP_SLEEP);

    // Result and flag computation for the instruction being taken
    always_comb begin
        next_status_flags_register = status_flags_register_cur;
        next_reg_en = 1'b0;
        next_reg_data = rv;
        next_io_en = 1'b0;
        next_io_data = io_rdata;
        if (take) begin
            case (req.op)
                bopx_pkg::OP_LOGICAL_SHIFT_UP: begin
                    next_reg_en = 1'b1;
                    next_reg_data = {rv[6:0], 1'b0};
                    next_status_flags_register = shift_flags(status_flags_register_cur, {rv[6:0], 1'b0}, rv[7], 1'b1, rv[3]);
                end
                bopx_pkg::OP_LOGICAL_SHIFT_DOWN: begin
                    next_reg_en = 1'b1;
                    next_reg_data = {1'b0, rv[7:1]};
                    next_status_flags_register = shift_flags(status_flags_register_cur, {1'b0, rv[7:1]}, rv[0], 1'b0, 1'b0);
                end
                bopx_pkg::OP_ROTATE_LEFT_CARRY: begin
                    next_reg_en = 1'b1;
                    next_reg_data = {rv[6:0], status_flags_register_cur[bopx_pkg::FLAG_C]};
                    next_status_flags_register = shift_flags(status_flags_register_cur, {rv[6:0], status_flags_register_cur[bopx_pkg::FLAG_C]},
                        rv[7], 1'b1, rv[3]);
                end
                bopx_pkg::OP_ROTATE_RIGHT_CARRY: begin
                    next_reg_en = 1'b1;
                    next_reg_data = {status_flags_register_cur[bopx_pkg::FLAG_C], rv[7:1]};
                    next_status_flags_register = shift_flags(status_flags_register_cur, {status_flags_register_cur[bopx_pkg::FLAG_C], rv[7:1]},
                        rv[0], 1'b0, 1'b0);
                end
                bopx_pkg::OP_ARITH_SHIFT_DOWN: begin
                    next_reg_en = 1'b1;
                    next_reg_data = {rv[7], rv[7:1]};
                    next_status_flags_register = shift_flags(status_flags_register_cur, {rv[7], rv[7:1]}, rv[0], 1'b0, 1'b0);
                end
                bopx_pkg::OP_NIBBLE_SWAP: begin
                    next_reg_en = 1'b1;
                    next_reg_data = {rv[3:0], rv[7:4]};
                end
                bopx_pkg::OP_IO_BIT_SET: begin
                    next_io_en = 1'b1;
                    next_io_data = io_rdata | sel_mask;
                end
                bopx_pkg::OP_IO_BIT_CLEAR: begin
                    next_io_en = 1'b1;
                    next_io_data = io_rdata & ~sel_mask;
                end
                bopx_pkg::OP_BIT_TO_TRANSFER_FLAG: begin
                    next_status_flags_register[bopx_pkg::FLAG_T] = |(rv & sel_mask);
                end
                bopx_pkg::OP_TRANSFER_FLAG_TO_BIT: begin
                    next_reg_en = 1'b1;
                    if (status_flags_register_cur[bopx_pkg::FLAG_T]) begin
                        next_reg_data = rv | sel_mask;
                    end else begin
                        next_reg_data = rv & ~sel_mask;
                    end
                end
                bopx_pkg::OP_GENERIC_FLAG_SET: begin
                    next_status_flags_register = status_flags_register_cur | sel_mask;
                end
                bopx_pkg::OP_GENERIC_FLAG_CLEAR: begin
                    next_status_flags_register = status_flags_register_cur & ~sel_mask;
                end
                bopx_pkg::OP_OVERFLOW_FLAG_SET: begin
                    next_status_flags_register[bopx_pkg::FLAG_V] = 1'b1;
                end
                bopx_pkg::OP_OVERFLOW_FLAG_CLEAR: begin
                    next_status_flags_register[bopx_pkg::FLAG_V] = 1'b0;
                end
                bopx_pkg::OP_HALF_CARRY_SET: begin
                    next_status_flags_register[bopx_pkg::FLAG_H] = 1'b1;
                end
                bopx_pkg::OP_HALF_CARRY_CLEAR: begin
                    next_status_flags_register[bopx_pkg::FLAG_H] = 1'b0;
                end
                bopx_pkg::OP_SIGNED_FLAG_SET: begin
                    next_status_flags_register[bopx_pkg::FLAG_S] = 1'b1;
                end
                bopx_pkg::OP_SIGNED_FLAG_CLEAR: begin
                    next_status_flags_register[bopx_pkg::FLAG_S] = 1'b0;
                end
                bopx_pkg::OP_GLOBAL_IRQ_ENABLE: begin
                    next_status_flags_register[bopx_pkg::FLAG_I] = 1'b1;
                end
                bopx_pkg::OP_GLOBAL_IRQ_DISABLE: begin
                    next_status_flags_register[bopx_pkg::FLAG_I] = 1'b0;
                end
                default: begin
                    next_status_flags_register = status_flags_register_cur;
                end
            endcase
        end
    end

    // Status register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            status_flags_register <= bopx_pkg::STATUS_FLAGS_REGISTER_RESET;
        end else begin
            status_flags_register <= next_status_flags_register;
        end
    end

    // Register file write-back
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_wr.en <= 1'b0;
            reg_wr.data <= bopx_pkg::BYTE_ZERO;
        end else begin
            reg_wr.en <= next_reg_en;
            if (next_reg_en) begin
                reg_wr.data <= next_reg_data;
            end
        end
    end

    // I/O read-modify-write; other bits come back unchanged
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            io_wr.en <= 1'b0;
            io_wr.addr <= '0;
            io_wr.data <= bopx_pkg::BYTE_ZERO;
        end else begin
            io_wr.en <= next_io_en;
            if (next_io_en) begin
                io_wr.addr <= req.io_addr;
                io_wr.data <= next_io_data;
            end
        end
    end

    // Processor-control pulses, one cycle each; sleep_mode_req holds the mode of the last sleep taken
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            debug_break <= 1'b0;
            sleep_req <= 1'b0;
            sleep_mode_req <= '0;
            watchdog_restart <= 1'b0;
        end else begin
            debug_break <= op_taken(take, req.op, bopx_pkg::OP_BREAK);
            sleep_req <= sleep_taken;
            if (sleep_taken) begin
                sleep_mode_req <= sleep_mode;
            end
            watchdog_restart <= op_taken(take, req.op, bopx_pkg::OP_WATCHDOG_RESTART);
        end
    end

    // Data access timing: internal RAM finishes at once, nonvolatile waits
    always_comb begin
        next_state = state;
        case (state)
            bopx_pkg::ST_RUN: begin
                if (nvm_access) begin
                    next_state = bopx_pkg::ST_NVM_WAIT;
                end
            end
            bopx_pkg::ST_NVM_WAIT: begin
                if (nvm_ready) begin
                    next_state = bopx_pkg::ST_RUN;
                end
            end
            default: begin
                next_state = bopx_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state <= bopx_pkg::ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Completion pulse for a data access
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            data_access_done <= 1'b0;
        end else begin
            data_access_done <= ram_access ||
                (stall && nvm_ready);
        end
    end

endmodule

/* File: src/bopx_pkg.sv */
// Package for the bit-manipulation and processor-control execution block.
// Assumes an 8-bit core with one status register and byte-wide register file and I/O space.
package bopx_pkg;

    localparam int DATA_W = 8;
    localparam int BIT_SEL_W = 3;
    localparam int IO_ADDR_W = 6;
    localparam int SLEEP_MODE_W = 3;

    // Status register bit positions
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;

    localparam logic [7:0] STATUS_FLAGS_REGISTER_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Fewest extra cycles added to a data access through the nonvolatile controller
    localparam int NVM_EXTRA_MIN = 1;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_LOGICAL_SHIFT_UP = 5'h01,
        OP_LOGICAL_SHIFT_DOWN = 5'h02,
        OP_ROTATE_LEFT_CARRY = 5'h03,
        OP_ROTATE_RIGHT_CARRY = 5'h04,
        OP_ARITH_SHIFT_DOWN = 5'h05,
        OP_NIBBLE_SWAP = 5'h06,
        OP_IO_BIT_SET = 5'h07,
        OP_IO_BIT_CLEAR = 5'h08,
        OP_BIT_TO_TRANSFER_FLAG = 5'h09,
        OP_TRANSFER_FLAG_TO_BIT = 5'h0a,
        OP_GENERIC_FLAG_SET = 5'h0b,
        OP_GENERIC_FLAG_CLEAR = 5'h0c,
        OP_OVERFLOW_FLAG_SET = 5'h0d,
        OP_OVERFLOW_FLAG_CLEAR = 5'h0e,
        OP_HALF_CARRY_SET = 5'h0f,
        OP_HALF_CARRY_CLEAR = 5'h10,
        OP_SIGNED_FLAG_SET = 5'h11,
        OP_SIGNED_FLAG_CLEAR = 5'h12,
        OP_GLOBAL_IRQ_ENABLE = 5'h13,
        OP_GLOBAL_IRQ_DISABLE = 5'h14,
        OP_BREAK = 5'h15,
        OP_SLEEP = 5'h16,
        OP_WATCHDOG_RESTART = 5'h17,
        OP_DATA_ACCESS = 5'h18
    } bopx_op_t;

    typedef enum logic [0:0] {
        ST_RUN = 1'b0,
        ST_NVM_WAIT = 1'b1
    } bopx_state_t;

    typedef struct packed {
        bopx_op_t op;
        logic [DATA_W-1:0] reg_value;
        logic [BIT_SEL_W-1:0] bit_sel;
        logic [IO_ADDR_W-1:0] io_addr;
        logic via_nvm;
    } bopx_req_t;

    typedef struct packed {
        logic en;
        logic [DATA_W-1:0] data;
    } bopx_reg_wr_t;

    typedef struct packed {
        logic en;
        logic [IO_ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } bopx_io_wr_t;

endpackage

/* File: verification/bopx_exec_chk.sv */
// Port checker for the bit-operation execution unit.
// Assumes one clock, core_clk, and an active-low asynchronous reset, nrst.
`timescale 1ns/10ps
module bopx_exec_chk (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic req_valid,
    input wire bopx_pkg::bopx_req_t req,
    input wire logic req_ready,
    input wire logic [7:0] io_rdata,
    input wire logic nvm_ready,
    input wire logic [2:0] sleep_mode,
    input wire bopx_pkg::bopx_reg_wr_t reg_wr,
    input wire bopx_pkg::bopx_io_wr_t io_wr,
    input wire logic [7:0] status_flags_register,
    input wire logic debug_break,
    input wire logic sleep_req,
    input wire logic [2:0] sleep_mode_req,
    input wire logic watchdog_restart,
    input wire logic data_access_done,
    input wire logic stall
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    wire t = req_valid && req_ready;
    wire [4:0] op = req.op;
    wire [7:0] f = status_flags_register;
    wire sel_bit = req.reg_value[req.bit_sel];
    a_rotate_left: assert property (t && op == bopx_pkg::OP_ROTATE_LEFT_CARRY |=>
        reg_wr.en && f[0] == $past(req.reg_value[7]) && reg_wr.data == {$past(req.reg_value[6:0]), $past(f[0])})
        else $error("rotate left result wrong");
    a_rotate_right: assert property (t && op == bopx_pkg::OP_ROTATE_RIGHT_CARRY |=>
        reg_wr.en && f[0] == $past(req.reg_value[0]) && reg_wr.data == {$past(f[0]), $past(req.reg_value[7:1])})
        else $error("rotate right result wrong");
    a_io_set: assert property (t && op == bopx_pkg::OP_IO_BIT_SET |=> io_wr.en && $stable(f)
        && io_wr.data == ($past(io_rdata) | (8'h01 << $past(req.bit_sel)))) else $error("io bit set wrong");
    a_io_clear: assert property (t && op == bopx_pkg::OP_IO_BIT_CLEAR |=> io_wr.en && $stable(f)
        && io_wr.data == ($past(io_rdata) & ~(8'h01 << $past(req.bit_sel)))) else $error("io bit clear wrong");
    a_bit_store: assert property (t && op == bopx_pkg::OP_BIT_TO_TRANSFER_FLAG |=> f[6] == $past(sel_bit)
        && (f & 8'hbf) == ($past(f) & 8'hbf)) else $error("bit store to transfer flag wrong");
    a_bit_load: assert property (t && op == bopx_pkg::OP_TRANSFER_FLAG_TO_BIT |=> reg_wr.en && $stable(f)
        && reg_wr.data[$past(req.bit_sel)] == $past(f[6])) else $error("bit load from transfer flag wrong");
    a_break_pulse: assert property (t && op == bopx_pkg::OP_BREAK |=> debug_break && $stable(f))
        else $error("break pulse missing");
    a_sleep_request: assert property (t && op == bopx_pkg::OP_SLEEP |=> sleep_req && $stable(f)
        && sleep_mode_req == $past(sleep_mode)) else $error("sleep request wrong");
    a_watchdog_pulse: assert property (t && op == bopx_pkg::OP_WATCHDOG_RESTART |=> watchdog_restart
        && $stable(f)) else $error("watchdog restart missing");
    a_nvm_extra_cycle: assert property (t && op == bopx_pkg::OP_DATA_ACCESS && req.via_nvm |=>
        stall && !data_access_done) else $error("nvm access without extra cycle");
    a_nvm_wait_hold: assert property (stall && !nvm_ready |=> stall && !data_access_done)
        else $error("nvm wait ended while not ready");
    c_nvm_stall: cover property (stall ##1 !stall);
    c_sleep: cover property (sleep_req);
    c_io_write: cover property (io_wr.en);
endmodule
bind bopx_exec bopx_exec_chk chk_u (
    .core_clk(core_clk),
    .nrst(nrst),
    .req_valid(req_valid),
    .req(req),
    .req_ready(req_ready),
    .io_rdata(io_rdata),
    .nvm_ready(nvm_ready),
    .sleep_mode(sleep_mode),
    .reg_wr(reg_wr),
    .io_wr(io_wr),
    .status_flags_register(status_flags_register),
    .debug_break(debug_break),
    .sleep_req(sleep_req),
    .sleep_mode_req(sleep_mode_req),
    .watchdog_restart(watchdog_restart),
    .data_access_done(data_access_done),
    .stall(stall)
);

/* File: verification/tb_top.sv */
// Self-checking bench for the bit-operation execution unit.
// Assumes bopx_exec with its checker bound from the checker file.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_top;
    typedef struct {logic [4:0] op; logic [7:0] rv; logic [2:0] bs;
        logic [7:0] ir, er, ei, ef; logic [4:0] en;} bopx_row_t;
    logic core_clk = 0, nrst = 0, req_valid = 0, nvm_ready = 0;
    bopx_pkg::bopx_req_t req = '0;
    logic [7:0] io_rdata = 8'h00;
    logic [2:0] sleep_mode = 3'h5;
    logic req_ready, debug_break, sleep_req, watchdog_restart, data_access_done, stall;
    bopx_pkg::bopx_reg_wr_t reg_wr;
    bopx_pkg::bopx_io_wr_t io_wr;
    logic [7:0] status_flags_register;
    logic [2:0] sleep_mode_req;
    int errors = 0, checked = 0, cycles = 0;
    // Rows: op, reg value, bit, io read, reg data, io data, flags, {reg, io, break, sleep, wdr}
    bopx_row_t rows[24] = '{
        '{5'h0b, 8'h00, 3'h0, 8'h00, 8'h00, 8'h00, 8'h01, 5'h00},
        '{5'h03, 8'h81, 3'h0, 8'h00, 8'h03, 8'h00, 8'h19, 5'h10},
        '{5'h04, 8'h02, 3'h0, 8'h00, 8'h81, 8'h00, 8'h0c, 5'h10},
        '{5'h01, 8'h88, 3'h0, 8'h00, 8'h10, 8'h00, 8'h39, 5'h10},
        '{5'h02, 8'h01, 3'h0, 8'h00, 8'h00, 8'h00, 8'h3b, 5'h10},
        '{5'h05, 8'h80, 3'h0, 8'h00, 8'hc0, 8'h00, 8'h2c, 5'h10},
        '{5'h06, 8'h5a, 3'h0, 8'h00, 8'ha5, 8'h00, 8'h2c, 5'h10},
        '{5'h0e, 8'h00, 3'h0, 8'h00, 8'h00, 8'h00, 8'h24, 5'h00},
        '{5'h0d, 8'h00, 3'h0, 8'h00, 8'h00, 8'h00, 8'h2c, 5'h00},
        '{5'h10, 8'h00, 3'h0, 8'h00, 8'h00, 8'h00, 8'h0c, 5'h00},
        '{5'h0f, 8'h00, 3'h0, 8'h00, 8'h00, 8'h00, 8'h2c, 5'h00},
        '{5'h11, 8'h00, 3'h0, 8'h00, 8'h00, 8'h00, 8'h3c, 5'h00},
        '{5'h12, 8'h00, 3'h0, 8'h00, 8'h00, 8'h00, 8'h2c, 5'h00},
        '{5'h13, 8'h00, 3'h0, 8'h00, 8'h00, 8'h00, 8'hac, 5'h00},
        '{5'h14, 8'h00, 3'h0, 8'h00, 8'h00, 8'h00, 8'h2c, 5'h00},
        '{5'h09, 8'h10, 3'h4, 8'h00, 8'h00, 8'h00, 8'h6c, 5'h00},
        '{5'h0a, 8'h00, 3'h7, 8'h00, 8'h80, 8'h00, 8'h6c, 5'h10},
        '{5'h09, 8'hef, 3'h4, 8'h00, 8'h00, 8'h00, 8'h2c, 5'h00},
        '{5'h07, 8'h00, 3'h7, 8'h01, 8'h00, 8'h81, 8'h2c, 5'h08},
        '{5'h08, 8'h00, 3'h0, 8'hff, 8'h00, 8'hfe, 8'h2c, 5'h08},
        '{5'h0c, 8'h00, 3'h5, 8'h00, 8'h00, 8'h00, 8'h0c, 5'h00},
        '{5'h15, 8'h00, 3'h0, 8'h00, 8'h00, 8'h00, 8'h0c, 5'h04},
        '{5'h17, 8'h00, 3'h0, 8'h00, 8'h00, 8'h00, 8'h0c, 5'h01},
        '{5'h16, 8'h00, 3'h0, 8'h00, 8'h00, 8'h00, 8'h0c, 5'h02}};
    bopx_exec dut_u (
        .core_clk(core_clk),
        .nrst(nrst),
        .req_valid(req_valid),
        .req(req),
        .req_ready(req_ready),
        .io_rdata(io_rdata),
        .nvm_ready(nvm_ready),
        .sleep_mode(sleep_mode),
        .reg_wr(reg_wr),
        .io_wr(io_wr),
        .status_flags_register(status_flags_register),
        .debug_break(debug_break),
        .sleep_req(sleep_req),
        .sleep_mode_req(sleep_mode_req),
        .watchdog_restart(watchdog_restart),
        .data_access_done(data_access_done),
        .stall(stall)
    );
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    task automatic end_sim();
        $display("Counts: checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic drive(input logic [4:0] op, input logic [7:0] rv, input logic [2:0] bs, input logic [7:0] ir,
        input logic nv);
        req_valid = 1'b1;
        req = '{bopx_pkg::bopx_op_t'(op), rv, bs, 6'h2a, nv};
        io_rdata = ir;
    endtask
    task automatic step();
        @(posedge core_clk);
        #10;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 500) begin
            errors++;
            end_sim();
        end
    end
    initial begin
        repeat (8) @(posedge core_clk);
        `CHK("flags in reset", 8'h00, status_flags_register)
        `CHK("ready in reset", 1'b1, req_ready)
        #10 nrst = 1'b1;
        foreach (rows[i]) begin
            drive(rows[i].op, rows[i].rv, rows[i].bs, rows[i].ir, 1'b0);
            step();
            `CHK("flags", rows[i].ef, status_flags_register)
            `CHK("strobes", rows[i].en, {reg_wr.en, io_wr.en, debug_break, sleep_req, watchdog_restart})
            if (rows[i].en[4]) `CHK("reg data", rows[i].er, reg_wr.data)
            if (rows[i].en[3]) `CHK("io data", rows[i].ei, io_wr.data)
            if (rows[i].en[3]) `CHK("io addr", 6'h2a, io_wr.addr)
        end
        `CHK("sleep mode", 3'h5, sleep_mode_req)
        $display("Test table done");
        drive(5'h18, 8'h00, 3'h0, 8'h00, 1'b0);
        step();
        `CHK("ram access", 2'b10, {data_access_done, stall})
        drive(5'h18, 8'h00, 3'h0, 8'h00, 1'b1);
        step();
        drive(5'h11, 8'h00, 3'h0, 8'h00, 1'b0);
        repeat (3) begin
            `CHK("nvm wait", 3'b010, {data_access_done, stall, req_ready})
            step();
        end
        nvm_ready = 1'b1;
        step();
        nvm_ready = 1'b0;
        `CHK("nvm done", 3'b101, {data_access_done, stall, req_ready})
        `CHK("refused flags", 8'h0c, status_flags_register)
        step();
        `CHK("held request", 8'h1c, status_flags_register)
        nvm_ready = 1'b1;
        drive(5'h18, 8'h00, 3'h0, 8'h00, 1'b1);
        step();
        `CHK("nvm extra cycle", 2'b01, {data_access_done, stall})
        req_valid = 1'b0;
        repeat (bopx_pkg::NVM_EXTRA_MIN) step();
        `CHK("nvm shortest", 2'b10, {data_access_done, stall})
        nvm_ready = 1'b0;
        $display("Test nvm done");
        nrst = 1'b0;
        #10;
        `CHK("flags after reset", 8'h00, status_flags_register)
        `CHK("outputs after reset", 7'h00, {reg_wr.en, io_wr.en, debug_break, sleep_req, watchdog_restart,
            data_access_done, stall})
        step();
        nrst = 1'b1;
        drive(5'h0b, 8'h00, 3'h7, 8'h00, 1'b0);
        step();
        `CHK("first op after reset", 8'h80, status_flags_register)
        $display("Test reset done");
        end_sim();
    end
endmodule
